// ==== include/ahi_pkg.sv ====
// Constants for the host interface register block
package ahi_pkg;
  // Microcontroller register addresses
  localparam logic [15:0] UA_FIFO = 16'hff80;
  localparam logic [15:0] UA_MASK = 16'hff81;
  localparam logic [15:0] UA_BCL = 16'hff82;
  localparam logic [15:0] UA_BCH = 16'hff83;
  localparam logic [15:0] UA_START = 16'hff84;
  localparam logic [15:0] UA_ACK = 16'hff85;
  localparam logic [15:0] UA_RESET = 16'hff86;
  localparam logic [15:0] UA_STATUS = 16'hff87;
  localparam logic [15:0] UA_HIRQ = 16'hff88;
  localparam logic [15:0] UA_DADDR = 16'hff89;
  localparam logic [15:0] UA_SAMTAG = 16'hff8a;
  localparam logic [15:0] UA_FLOW = 16'hff8b;
  localparam logic [15:0] UA_DSEL = 16'hff8c;
  localparam logic [15:0] UA_IREASON = 16'hff8d;
  localparam logic [15:0] UA_ERROR = 16'hff8e;
  localparam logic [15:0] UA_CMD = 16'hff8f;
  localparam logic [15:0] UA_DEVCTL = 16'hff90;
  localparam logic [15:0] UA_FEAT = 16'hff91;
  localparam logic [15:0] UA_FLAGS = 16'hff92;
  localparam logic [15:0] UA_SHADOW_ERROR = 16'hff98;
  localparam logic [15:0] UA_PINS = 16'hff99;
  localparam logic [15:0] UA_INTERFACE_IRQ_FLAGS = 16'hff9a;
  localparam logic [15:0] UA_XC0 = 16'hffa0;
  localparam logic [15:0] UA_XC1 = 16'hffa1;
  localparam logic [15:0] UA_XC2 = 16'hffa2;
  localparam logic [15:0] UA_XC3 = 16'hffa3;
  localparam logic [15:0] UA_PKL = 16'hffa4;
  localparam logic [15:0] UA_PKH = 16'hffa5;
  localparam logic [15:0] UA_SEQ = 16'hffa6;
  // Host task-file select codes {cs0_n, cs1_n, da2..da0}
  localparam logic [4:0] HC_DATA = 5'h08;
  localparam logic [4:0] HC_ERROR = 5'h09;
  localparam logic [4:0] HC_IREASON = 5'h0a;
  localparam logic [4:0] HC_SAMTAG = 5'h0b;
  localparam logic [4:0] HC_BCL = 5'h0c;
  localparam logic [4:0] HC_BCH = 5'h0d;
  localparam logic [4:0] HC_DSEL = 5'h0e;
  localparam logic [4:0] HC_STATUS = 5'h0f;
  localparam logic [4:0] HC_ALTSTAT = 5'h16;
  localparam logic [4:0] HC_DADDR = 5'h17;
  // Host mode select codes
  localparam logic [2:0] HSEL_OFF = 3'h0;
  localparam logic [2:0] HSEL_ATAPI = 3'h1;
  localparam logic [2:0] HSEL_GEN8 = 3'h3;
  localparam logic [2:0] HSEL_GEN16 = 3'h4;
  // Transfer type codes
  localparam logic [2:0] XT_MEM_TO_HOST = 3'h0;
  localparam logic [2:0] XT_HOST_TO_MEM = 3'h1;
  localparam logic [2:0] XT_UC_TO_HOST = 3'h5;
  // Field positions
  localparam int F_CMDI = 7;
  localparam int F_DTEI = 6;
  localparam int F_DRQI = 5;
  localparam int F_USTOP = 4;
  localparam int F_DTBSY = 3;
  localparam int F_SRSTI = 2;
  localparam int F_PKT = 0;
  localparam int ST_BSY = 7;
  localparam int DC_SRST = 2;
  localparam int DS_DRV = 4;
  localparam int FL_RDRV = 3;
  localparam int SE_ABRT = 2;
  localparam int PN_PDIAG_OUT = 7;
  localparam int PN_PDIAG_EN = 6;
  localparam int PN_DASP_OUT = 5;
  localparam int PN_DASP_EN = 4;
  localparam int PN_PDIAG_IN = 3;
  localparam int PN_DASP_IN = 2;
  localparam int DA_FLOAT = 7;
  // Reset values and sizes
  localparam logic [7:0] RST_FLOW = 8'h08;
  localparam logic [7:0] RST_DSEL = 8'he0;
  localparam logic [7:0] RST_STATUS = 8'h80;
  localparam logic [7:0] DIAG_CMD = 8'h90;
  localparam logic [3:0] FIFO_DEPTH = 4'hc;
  localparam logic [3:0] FIFO_LAST = 4'hb;
endpackage

// ==== hw/ahi_regs.sv ====
// Host interface register block: microcontroller bank and host task file
// Notes on behaviour
// - Microcontroller-to-host data path is a 12-byte FIFO, used only with type 101.
// - Interrupt enables only gate the microcontroller interrupt; flags untouched.
// - Soft-reset enable at bit 2 is inverted; cleared means enabled.
// - 16-bit byte count readable and writable by host and microcontroller.
// - Memory-to-host: byte count decrements after each host data read.
// - Host-to-memory: byte count decrements per buffer memory write.
// - Byte count reloadable from packet store, counter remainder or microcontroller.
// - Any write to the start strobe register starts a transfer; data ignored.
// - Any write to the acknowledge register clears transfer-end and packet flags.
// - Write to reset register defaults all registers, loads host mode.
// - Host mode 000 off, 001 ATAPI, 011 generic 8, 100 generic 16.
// - Busy set when host writes command while this drive is selected.
// - Busy set when host writes diagnostic command 90H.
// - Busy set on host soft reset bit write and on hardware reset.
// - Microcontroller status write clears a pending host interrupt.
// - In ATAPI mode host interrupt strobe write raises the host interrupt.
// - Host interrupt clears on host status read or command write.
// - Drive address answers code 10111; its bit 7 floats on host reads.
// - Task-file registers reset to zero except busy in status and E0H in drive select.
// - 32-bit transfer counter at FFA0H; 16-bit packet size store.
// - Sequencer state register is read-only, state in bits 5 to 0.
// - Drive is selected only when drive bit equals configured device bit.
`timescale 1ns/1ps
module ahi_regs (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [15:0] uc_addr_i,
  input wire logic [7:0] uc_wdata_i,
  input wire logic uc_wr_i,
  input wire logic uc_rd_i,
  output logic [7:0] uc_rdata_o,
  output logic uc_irq_o,
  input wire logic host_cs0_n_i,
  input wire logic host_cs1_n_i,
  input wire logic [2:0] host_da_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic [7:0] host_data_oe_n_o,
  output logic host_intrq_o,
  output logic host_intrq_oe_n_o,
  input wire logic pdiag_i,
  output logic pdiag_o,
  output logic pdiag_oe_n_o,
  input wire logic dasp_i,
  output logic dasp_o,
  output logic dasp_oe_n_o,
  input wire logic [7:0] mem_data_i,
  input wire logic buf_wr_i,
  input wire logic xfer_done_i,
  input wire logic drq_evt_i,
  input wire logic ultra_stop_i,
  input wire logic pkt_done_i,
  input wire logic load_pkt_i,
  input wire logic load_rem_i,
  input wire logic [5:0] seq_state_i,
  output logic xfer_start_o,
  output logic [2:0] host_mode_o
);

  typedef struct packed {
    logic [7:0] irq_mask;
    logic [7:0] irq_flags;
    logic [15:0] byte_count;
    logic [2:0] hsel;
    logic [7:0] status;
    logic [7:0] command;
    logic [7:0] devctrl;
    logic [7:0] feature;
    logic [7:0] error;
    logic [7:0] intr_reason;
    logic [7:0] sam_tag;
    logic [7:0] drive_sel;
    logic [7:0] drive_addr;
    logic [7:0] flow;
    logic [7:0] sh_error;
    logic [7:0] pin_ctrl;
    logic [31:0] xfer_count;
    logic [15:0] pkt_len;
    logic [11:0][7:0] fifo;
    logic [3:0] fifo_wr;
    logic [3:0] fifo_rd;
    logic [3:0] fifo_cnt;
    logic host_irq;
    logic [7:0] uc_rdata;
    logic [7:0] host_rdata;
    logic [7:0] host_oe_n;
    logic uc_irq;
    logic xfer_start;
    logic host_intrq;
  } ahi_state_type;

  ahi_state_type q;
  ahi_state_type d;

  // Default contents after any reset; busy set, drive 1, host pins off
  function automatic ahi_state_type reset_state();
    ahi_state_type s;
    s = '0;
    s.status = ahi_pkg::RST_STATUS;
    s.flow = ahi_pkg::RST_FLOW;
    s.drive_sel = ahi_pkg::RST_DSEL;
    s.host_oe_n = 8'hff;
    return s;
  endfunction

  // FIFO pointer advance with wrap at depth
  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    return (p == ahi_pkg::FIFO_LAST) ? 4'h0 : 4'(p + 4'h1);
  endfunction

  logic sel;
  logic host_on;
  logic [4:0] hcode;
  logic [2:0] trant;
  logic hrd;
  logic hwr;
  logic soft_rst;
  logic fifo_push;
  logic fifo_pop;
  logic [7:0] irq_en;

  // Decode of selection, strobes and FIFO moves
  always_comb begin
    sel = q.drive_sel[ahi_pkg::DS_DRV] == q.flow[ahi_pkg::FL_RDRV];
    host_on = q.hsel != ahi_pkg::HSEL_OFF;
    hcode = {host_cs0_n_i, host_cs1_n_i, host_da_i};
    trant = q.flow[2:0];
    hrd = host_rd_i && host_on;
    hwr = host_wr_i && host_on;
    soft_rst = uc_wr_i && uc_addr_i == ahi_pkg::UA_RESET;
    fifo_push = uc_wr_i && uc_addr_i == ahi_pkg::UA_FIFO && trant == ahi_pkg::XT_UC_TO_HOST
      && q.fifo_cnt != ahi_pkg::FIFO_DEPTH;
    fifo_pop = hrd && hcode == ahi_pkg::HC_DATA && trant == ahi_pkg::XT_UC_TO_HOST
      && q.fifo_cnt != 4'h0;
  end

  // Next state of every register
  always_comb begin
    d = q;
    d.xfer_start = 1'b0;
    irq_en = 8'h00;
    // Sample device pins every cycle
    d.pin_ctrl[ahi_pkg::PN_PDIAG_IN] = pdiag_i;
    d.pin_ctrl[ahi_pkg::PN_DASP_IN] = dasp_i;

    // Byte count counts down per moved byte
    if (q.byte_count != 16'h0000) begin
      if (trant == ahi_pkg::XT_MEM_TO_HOST && hrd && hcode == ahi_pkg::HC_DATA) begin
        d.byte_count = 16'(q.byte_count - 16'h0001);
      end else if (trant == ahi_pkg::XT_HOST_TO_MEM && buf_wr_i) begin
        d.byte_count = 16'(q.byte_count - 16'h0001);
      end
    end
    // Sequencer reloads of the byte count
    if (load_pkt_i) begin
      d.byte_count = q.pkt_len;
    end else if (load_rem_i) begin
      d.byte_count = q.xfer_count[15:0];
    end

    // FIFO storage and pointers
    if (fifo_push) begin
      d.fifo[q.fifo_wr] = uc_wdata_i;
      d.fifo_wr = next_ptr(q.fifo_wr);
    end
    if (fifo_pop) begin
      d.fifo_rd = next_ptr(q.fifo_rd);
    end
    d.fifo_cnt = 4'(q.fifo_cnt + {3'b000, fifo_push} - {3'b000, fifo_pop});

    // Microcontroller writes
    if (uc_wr_i) begin
      unique case (uc_addr_i)
        ahi_pkg::UA_MASK: d.irq_mask = uc_wdata_i;
        ahi_pkg::UA_BCL: d.byte_count[7:0] = uc_wdata_i;
        ahi_pkg::UA_BCH: d.byte_count[15:8] = uc_wdata_i;
        ahi_pkg::UA_START: begin
          d.xfer_start = 1'b1;
          d.irq_flags[ahi_pkg::F_DTBSY] = 1'b1;
        end
        ahi_pkg::UA_ACK: begin
          d.irq_flags[ahi_pkg::F_DTEI] = 1'b0;
          d.irq_flags[ahi_pkg::F_PKT] = 1'b0;
        end
        ahi_pkg::UA_STATUS: begin
          d.status = uc_wdata_i;
          d.host_irq = 1'b0;
        end
        ahi_pkg::UA_DADDR: d.drive_addr = uc_wdata_i;
        ahi_pkg::UA_SAMTAG: d.sam_tag = uc_wdata_i;
        ahi_pkg::UA_FLOW: d.flow = uc_wdata_i;
        ahi_pkg::UA_DSEL: d.drive_sel = uc_wdata_i | ahi_pkg::RST_DSEL;
        ahi_pkg::UA_IREASON: d.intr_reason = uc_wdata_i;
        ahi_pkg::UA_ERROR: d.error = uc_wdata_i;
        ahi_pkg::UA_FLAGS: d.irq_flags = q.irq_flags & ~uc_wdata_i;
        ahi_pkg::UA_SHADOW_ERROR: d.sh_error[ahi_pkg::SE_ABRT] = uc_wdata_i[ahi_pkg::SE_ABRT];
        ahi_pkg::UA_PINS: d.pin_ctrl[7:4] = uc_wdata_i[7:4];
        ahi_pkg::UA_XC0: d.xfer_count[7:0] = uc_wdata_i;
        ahi_pkg::UA_XC1: d.xfer_count[15:8] = uc_wdata_i;
        ahi_pkg::UA_XC2: d.xfer_count[23:16] = uc_wdata_i;
        ahi_pkg::UA_XC3: d.xfer_count[31:24] = uc_wdata_i;
        ahi_pkg::UA_PKL: d.pkt_len[7:0] = uc_wdata_i;
        ahi_pkg::UA_PKH: d.pkt_len[15:8] = uc_wdata_i;
        default: ;
      endcase
    end

    // Host writes to the task file
    if (hwr) begin
      unique case (hcode)
        ahi_pkg::HC_ERROR: d.feature = host_wdata_i;
        ahi_pkg::HC_SAMTAG: d.sam_tag = host_wdata_i;
        ahi_pkg::HC_BCL: d.byte_count[7:0] = host_wdata_i;
        ahi_pkg::HC_BCH: d.byte_count[15:8] = host_wdata_i;
        ahi_pkg::HC_DSEL: d.drive_sel = host_wdata_i | ahi_pkg::RST_DSEL;
        ahi_pkg::HC_STATUS: begin
          d.host_irq = 1'b0;
          if (sel || host_wdata_i == ahi_pkg::DIAG_CMD) begin
            d.command = host_wdata_i;
            d.status[ahi_pkg::ST_BSY] = 1'b1;
            d.irq_flags[ahi_pkg::F_CMDI] = 1'b1;
          end
        end
        ahi_pkg::HC_ALTSTAT: begin
          d.devctrl = host_wdata_i;
          if (host_wdata_i[ahi_pkg::DC_SRST]) begin
            d.status[ahi_pkg::ST_BSY] = 1'b1;
            d.irq_flags[ahi_pkg::F_SRSTI] = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Host status read drops the host interrupt
    if (hrd && hcode == ahi_pkg::HC_STATUS) begin
      d.host_irq = 1'b0;
    end
    // Interrupt strobe; placed last so a set beats a clear
    if (uc_wr_i && uc_addr_i == ahi_pkg::UA_HIRQ && q.hsel == ahi_pkg::HSEL_ATAPI) begin
      d.host_irq = 1'b1;
    end

    // Event flags set after software clears so a set wins
    if (xfer_done_i) begin
      d.irq_flags[ahi_pkg::F_DTEI] = 1'b1;
      d.irq_flags[ahi_pkg::F_DTBSY] = 1'b0;
    end
    if (drq_evt_i) begin
      d.irq_flags[ahi_pkg::F_DRQI] = 1'b1;
    end
    if (ultra_stop_i) begin
      d.irq_flags[ahi_pkg::F_USTOP] = 1'b1;
    end
    if (pkt_done_i) begin
      d.irq_flags[ahi_pkg::F_PKT] = 1'b1;
    end

    // Microcontroller read data, valid the cycle after the read
    d.uc_rdata = 8'h00;
    if (uc_rd_i) begin
      unique case (uc_addr_i)
        ahi_pkg::UA_MASK: d.uc_rdata = q.irq_mask;
        ahi_pkg::UA_BCL: d.uc_rdata = q.byte_count[7:0];
        ahi_pkg::UA_BCH: d.uc_rdata = q.byte_count[15:8];
        ahi_pkg::UA_STATUS: d.uc_rdata = q.status;
        ahi_pkg::UA_SAMTAG: d.uc_rdata = q.sam_tag;
        ahi_pkg::UA_FLOW: d.uc_rdata = q.flow;
        ahi_pkg::UA_DSEL: d.uc_rdata = q.drive_sel;
        ahi_pkg::UA_IREASON: d.uc_rdata = q.intr_reason;
        ahi_pkg::UA_ERROR: d.uc_rdata = q.error;
        ahi_pkg::UA_CMD: d.uc_rdata = q.command;
        ahi_pkg::UA_DEVCTL: d.uc_rdata = q.devctrl;
        ahi_pkg::UA_FEAT: d.uc_rdata = q.feature;
        ahi_pkg::UA_FLAGS: d.uc_rdata = q.irq_flags;
        ahi_pkg::UA_SHADOW_ERROR: d.uc_rdata = q.sh_error;
        ahi_pkg::UA_PINS: d.uc_rdata = q.pin_ctrl;
        ahi_pkg::UA_XC0: d.uc_rdata = q.xfer_count[7:0];
        ahi_pkg::UA_XC1: d.uc_rdata = q.xfer_count[15:8];
        ahi_pkg::UA_XC2: d.uc_rdata = q.xfer_count[23:16];
        ahi_pkg::UA_XC3: d.uc_rdata = q.xfer_count[31:24];
        ahi_pkg::UA_PKL: d.uc_rdata = q.pkt_len[7:0];
        ahi_pkg::UA_PKH: d.uc_rdata = q.pkt_len[15:8];
        ahi_pkg::UA_SEQ: d.uc_rdata = {2'b00, seq_state_i};
        default: d.uc_rdata = 8'h00;
      endcase
    end

    // Host read data and pad enables, one cycle after the read strobe
    d.host_rdata = 8'h00;
    d.host_oe_n = 8'hff;
    if (hrd && sel) begin
      d.host_oe_n = 8'h00;
      unique case (hcode)
        ahi_pkg::HC_DATA: d.host_rdata = (trant == ahi_pkg::XT_UC_TO_HOST) ?
          q.fifo[q.fifo_rd] : mem_data_i;
        ahi_pkg::HC_ERROR: d.host_rdata = q.error;
        ahi_pkg::HC_IREASON: d.host_rdata = q.intr_reason;
        ahi_pkg::HC_SAMTAG: d.host_rdata = q.sam_tag;
        ahi_pkg::HC_BCL: d.host_rdata = q.byte_count[7:0];
        ahi_pkg::HC_BCH: d.host_rdata = q.byte_count[15:8];
        ahi_pkg::HC_DSEL: d.host_rdata = q.drive_sel;
        ahi_pkg::HC_STATUS: d.host_rdata = q.status;
        ahi_pkg::HC_ALTSTAT: d.host_rdata = q.status;
        ahi_pkg::HC_DADDR: begin
          d.host_rdata = q.drive_addr;
          d.host_oe_n[ahi_pkg::DA_FLOAT] = 1'b1;
        end
        default: d.host_oe_n = 8'hff;
      endcase
    end

    // Soft reset: everything defaults, host mode from write data
    if (soft_rst) begin
      d = reset_state();
      d.hsel = uc_wdata_i[2:0];
    end

    // Interrupt gating and pin outputs from the next state
    irq_en[ahi_pkg::F_CMDI] = d.irq_mask[ahi_pkg::F_CMDI];
    irq_en[ahi_pkg::F_DTEI] = d.irq_mask[ahi_pkg::F_DTEI];
    irq_en[ahi_pkg::F_DRQI] = d.irq_mask[ahi_pkg::F_DRQI];
    irq_en[ahi_pkg::F_USTOP] = d.irq_mask[ahi_pkg::F_USTOP];
    irq_en[ahi_pkg::F_SRSTI] = ~d.irq_mask[ahi_pkg::F_SRSTI];
    d.uc_irq = |(d.irq_flags & irq_en);
    d.host_intrq = d.host_irq && d.hsel == ahi_pkg::HSEL_ATAPI
      && d.drive_sel[ahi_pkg::DS_DRV] == d.flow[ahi_pkg::FL_RDRV];
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      q <= reset_state();
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign uc_rdata_o = q.uc_rdata;
  assign uc_irq_o = q.uc_irq;
  assign host_rdata_o = q.host_rdata;
  assign host_data_oe_n_o = q.host_oe_n;
  assign host_intrq_o = q.host_intrq;
  assign host_intrq_oe_n_o = q.hsel == ahi_pkg::HSEL_OFF;
  assign pdiag_o = q.pin_ctrl[ahi_pkg::PN_PDIAG_OUT];
  assign pdiag_oe_n_o = ~q.pin_ctrl[ahi_pkg::PN_PDIAG_EN];
  assign dasp_o = q.pin_ctrl[ahi_pkg::PN_DASP_OUT];
  assign dasp_oe_n_o = ~q.pin_ctrl[ahi_pkg::PN_DASP_EN];
  assign xfer_start_o = q.xfer_start;
  assign host_mode_o = q.hsel;

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  AST_FIFO_BOUND: assert property (q.fifo_cnt <= ahi_pkg::FIFO_DEPTH)
    else $error("fifo count beyond depth");
  AST_MASK_KEEPS_FLAGS: assert property (
    (uc_wr_i && uc_addr_i == ahi_pkg::UA_MASK && !hwr && !xfer_done_i && !drq_evt_i
      && !ultra_stop_i && !pkt_done_i) |=> q.irq_flags == $past(q.irq_flags))
    else $error("mask write changed flags");
  AST_SRST_INVERTED: assert property (
    (q.irq_flags[ahi_pkg::F_SRSTI] && !q.irq_mask[ahi_pkg::F_SRSTI] && !uc_wr_i) |=> uc_irq_o)
    else $error("soft reset interrupt not raised while enable bit clear");
  AST_COUNT_DOWN: assert property (
    (trant == ahi_pkg::XT_MEM_TO_HOST && hrd && hcode == ahi_pkg::HC_DATA && !uc_wr_i && !hwr
      && !load_pkt_i && !load_rem_i && q.byte_count != 16'h0000)
      |=> q.byte_count == 16'($past(q.byte_count) - 16'h0001))
    else $error("byte count did not step down on host read");
  AST_START_PULSE: assert property (
    (uc_wr_i && uc_addr_i == ahi_pkg::UA_START) |=> xfer_start_o
      ##1 (xfer_start_o == $past(uc_wr_i && uc_addr_i == ahi_pkg::UA_START)))
    else $error("start strobe not a single pulse");
  AST_ACK_CLEARS: assert property (
    (uc_wr_i && uc_addr_i == ahi_pkg::UA_ACK && !xfer_done_i && !pkt_done_i)
      |=> !q.irq_flags[ahi_pkg::F_DTEI] && !q.irq_flags[ahi_pkg::F_PKT])
    else $error("acknowledge left flags set");
  AST_SOFT_RESET: assert property (
    soft_rst |=> q.hsel == $past(uc_wdata_i[2:0]) && q.irq_mask == 8'h00
      && q.status == ahi_pkg::RST_STATUS)
    else $error("soft reset did not default registers");
  AST_OFF_FLOATS: assert property (
    (q.hsel == ahi_pkg::HSEL_OFF) |=> host_data_oe_n_o == 8'hff)
    else $error("host data driven while host mode off");
  AST_BSY_ON_CMD: assert property (
    (hwr && hcode == ahi_pkg::HC_STATUS && (sel || host_wdata_i == ahi_pkg::DIAG_CMD)
      && !soft_rst && !uc_wr_i) |=> q.status[ahi_pkg::ST_BSY])
    else $error("busy not set on command write");
  AST_HIRQ_SET: assert property (
    (uc_wr_i && uc_addr_i == ahi_pkg::UA_HIRQ && q.hsel == ahi_pkg::HSEL_ATAPI) |=> q.host_irq)
    else $error("host interrupt strobe ignored");
  AST_HIRQ_CLEAR: assert property (
    (hrd && hcode == ahi_pkg::HC_STATUS && !uc_wr_i) |=> !q.host_irq && !host_intrq_o)
    else $error("host interrupt kept after status read");
  AST_ADDR_FLOAT: assert property (
    (hrd && hcode == ahi_pkg::HC_DADDR) |=> host_data_oe_n_o[ahi_pkg::DA_FLOAT])
    else $error("drive address bit 7 driven");
  AST_SEQ_READ: assert property (
    (uc_rd_i && uc_addr_i == ahi_pkg::UA_SEQ) |=> uc_rdata_o == {2'b00, $past(seq_state_i)})
    else $error("sequencer state read wrong");
endmodule

// ==== test/ahi_host_model.sv ====
// Behavioural PC host on the task-file bus
`timescale 1ns/1ps
module ahi_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic cs0_n_o,
  output logic cs1_n_o,
  output logic [2:0] da_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  // Idle bus: selects released, no strobes
  initial begin
    {cs0_n_o, cs1_n_o, da_o} = 5'h1f;
    {rd_o, wr_o} = 2'b00;
    wdata_o = 8'h00;
  end
  // One access; held until the taking edge, data inverted once released
  task automatic acc(input logic [4:0] c, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge mclk_i);
    {cs0_n_o, cs1_n_o, da_o} <= c;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge mclk_i);
    {cs0_n_o, cs1_n_o, da_o} <= 5'h1f;
    {rd_o, wr_o} <= 2'b00;
    wdata_o <= ~d;
    #1 q = rdata_i;
  endtask
endmodule

// ==== test/test_ahi_regs.sv ====
// Self-checking bench for the host interface register block
`timescale 1ns/1ps
module test_ahi_regs;
  logic mclk_i = 0;
  logic reset_i = 1;
  logic [15:0] ua = 0;
  logic [7:0] uwd = 0, md = 0, q, x, y;
  logic [7:0] fb [13];
  logic [7:0] xc [4];
  logic uwr = 0, urd = 0;
  logic [1:0] pins = 0;
  logic [6:0] ev = 0;
  logic [5:0] seq = 0;
  wire [7:0] urdata, hrdata, hwd, oe;
  wire cs0, cs1, hrd, hwr, irq, hirq, hoe, xs, pd, pde, da, dae;
  wire [2:0] hda, mode;
  int fails = 0, samples_checked = 0;
  localparam logic [15:0] RA [6] = '{16'hff87, 16'hff8b, 16'hff8c, 16'hff81, 16'hff82, 16'hffb0};
  localparam logic [7:0] RE [6] = '{8'h80, 8'h08, 8'he0, 8'h00, 8'h00, 8'h00};
  localparam logic [2:0] HM [4] = '{3'h0, 3'h3, 3'h4, 3'h1};
  always #50 mclk_i = ~mclk_i;
  ahi_host_model host (.mclk_i(mclk_i), .rdata_i(hrdata), .cs0_n_o(cs0), .cs1_n_o(cs1),
    .da_o(hda), .rd_o(hrd), .wr_o(hwr), .wdata_o(hwd));
  ahi_regs DUT (.mclk_i(mclk_i), .reset_i(reset_i), .uc_addr_i(ua), .uc_wdata_i(uwd),
    .uc_wr_i(uwr), .uc_rd_i(urd), .uc_rdata_o(urdata), .uc_irq_o(irq),
    .host_cs0_n_i(cs0), .host_cs1_n_i(cs1), .host_da_i(hda), .host_rd_i(hrd),
    .host_wr_i(hwr), .host_wdata_i(hwd), .host_rdata_o(hrdata), .host_data_oe_n_o(oe),
    .host_intrq_o(hirq), .host_intrq_oe_n_o(hoe), .pdiag_i(pins[0]), .pdiag_o(pd),
    .pdiag_oe_n_o(pde), .dasp_i(pins[1]), .dasp_o(da), .dasp_oe_n_o(dae),
    .mem_data_i(md), .buf_wr_i(ev[0]), .xfer_done_i(ev[6]), .drq_evt_i(ev[5]),
    .ultra_stop_i(ev[4]), .pkt_done_i(ev[3]), .load_pkt_i(ev[1]), .load_rem_i(ev[2]),
    .seq_state_i(seq), .xfer_start_o(xs), .host_mode_o(mode));
  // Comparison and verdict
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Expected pin levels {pdiag out, pdiag oe_n, dasp out, dasp oe_n} from a control write
  function automatic logic [7:0] pin_exp(input logic [7:0] w);
    return {4'h0, w[7], !w[6], w[5], !w[4]};
  endfunction
  // Microcontroller access, read data kept in q
  task automatic uacc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk_i);
    ua <= a;
    uwd <= d;
    uwr <= w;
    urd <= !w;
    @(posedge mclk_i);
    uwr <= 0;
    urd <= 0;
    #1 q = urdata;
  endtask
  task automatic pulse(input int b);
    @(posedge mclk_i);
    ev[b] <= 1;
    @(posedge mclk_i);
    ev[b] <= 0;
    #1;
  endtask
  // Hang guard
  initial begin
    #3_000_000;
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    void'($urandom(41));
    md = $urandom;
    repeat (6) @(posedge mclk_i);
    reset_i <= 0;
    foreach (RA[i]) begin
      uacc(RA[i], 0, 0);
      chk("reset value", RE[i], q);
    end
    uacc(ahi_pkg::UA_SAMTAG, 1, 8'h5a);
    foreach (HM[i]) begin
      uacc(ahi_pkg::UA_RESET, 1, {5'h1f, HM[i]});
      chk("host mode", {5'h0, HM[i]}, {5'h0, mode});
      chk("host irq pad", {7'h0, HM[i] == 3'h0}, {7'h0, hoe});
    end
    uacc(ahi_pkg::UA_SAMTAG, 0, 0);
    chk("soft reset default", 8'h00, q);
    uacc(ahi_pkg::UA_DSEL, 1, 8'hf0);
    x = $urandom_range(255, 2);
    y = $urandom;
    uacc(ahi_pkg::UA_BCL, 1, x);
    host.acc(ahi_pkg::HC_BCL, 0, 0, q);
    chk("count low by host", x, q);
    host.acc(ahi_pkg::HC_BCH, 1, y, q);
    uacc(ahi_pkg::UA_BCH, 0, 0);
    chk("count high by uc", y, q);
    host.acc(ahi_pkg::HC_DATA, 0, 0, q);
    chk("memory data", md, q);
    uacc(ahi_pkg::UA_BCL, 0, 0);
    chk("count after host read", x - 8'h01, q);
    uacc(ahi_pkg::UA_FLOW, 1, 8'h09);
    pulse(0);
    uacc(ahi_pkg::UA_BCL, 0, 0);
    chk("count after buffer write", x - 8'h02, q);
    uacc(ahi_pkg::UA_PKL, 1, y);
    pulse(1);
    host.acc(ahi_pkg::HC_BCL, 0, 0, q);
    chk("packet reload", y, q);
    foreach (xc[i]) begin
      xc[i] = $urandom;
      uacc(ahi_pkg::UA_XC0 + 16'(i), 1, xc[i]);
    end
    foreach (xc[i]) begin
      uacc(ahi_pkg::UA_XC0 + 16'(i), 0, 0);
      chk("transfer counter", xc[i], q);
    end
    pulse(2);
    uacc(ahi_pkg::UA_BCH, 0, 0);
    chk("remainder reload", xc[1], q);
    seq <= 6'($urandom);
    uacc(ahi_pkg::UA_SEQ, 1, 8'hff);
    uacc(ahi_pkg::UA_SEQ, 0, 0);
    chk("sequencer state", {2'b00, seq}, q);
    uacc(ahi_pkg::UA_START, 1, $urandom);
    chk("start pulse", 8'h01, {7'h0, xs});
    uacc(ahi_pkg::UA_MASK, 1, 8'h44);
    pulse(6);
    pulse(3);
    chk("uc irq enabled", 8'h01, {7'h0, irq});
    uacc(ahi_pkg::UA_MASK, 1, 8'h04);
    uacc(ahi_pkg::UA_FLAGS, 0, 0);
    chk("flags kept", 8'h41, q & 8'h41);
    chk("uc irq masked", 8'h00, {7'h0, irq});
    uacc(ahi_pkg::UA_ACK, 1, $urandom);
    uacc(ahi_pkg::UA_FLAGS, 0, 0);
    chk("flags acked", 8'h00, q & 8'h41);
    uacc(ahi_pkg::UA_STATUS, 1, 8'h00);
    host.acc(ahi_pkg::HC_ALTSTAT, 1, 8'h04, q);
    uacc(ahi_pkg::UA_STATUS, 0, 0);
    chk("busy on srst", 8'h80, q & 8'h80);
    chk("srst irq disabled", 8'h00, {7'h0, irq});
    uacc(ahi_pkg::UA_MASK, 1, 8'h00);
    chk("srst irq enabled", 8'h01, {7'h0, irq});
    uacc(ahi_pkg::UA_STATUS, 1, 8'h00);
    host.acc(ahi_pkg::HC_STATUS, 1, 8'ha0, q);
    uacc(ahi_pkg::UA_STATUS, 0, 0);
    chk("busy on command", 8'h80, q & 8'h80);
    uacc(ahi_pkg::UA_DSEL, 1, 8'he0);
    uacc(ahi_pkg::UA_STATUS, 1, 8'h00);
    host.acc(ahi_pkg::HC_STATUS, 1, ahi_pkg::DIAG_CMD, q);
    uacc(ahi_pkg::UA_STATUS, 0, 0);
    chk("busy on diagnostic", 8'h80, q & 8'h80);
    uacc(ahi_pkg::UA_DSEL, 1, 8'hf0);
    uacc(ahi_pkg::UA_HIRQ, 1, $urandom);
    chk("host irq raised", 8'h01, {7'h0, hirq});
    host.acc(ahi_pkg::HC_STATUS, 0, 0, q);
    @(posedge mclk_i);
    #1 chk("host irq by status read", 8'h00, {7'h0, hirq});
    uacc(ahi_pkg::UA_HIRQ, 1, $urandom);
    uacc(ahi_pkg::UA_STATUS, 1, 8'h00);
    @(posedge mclk_i);
    #1 chk("host irq by uc status", 8'h00, {7'h0, hirq});
    host.acc(ahi_pkg::HC_DADDR, 0, 0, q);
    chk("drive address float", 8'h80, oe);
    pins <= 2'($urandom);
    uacc(ahi_pkg::UA_PINS, 1, 8'hd0);
    chk("pin outputs", pin_exp(8'hd0), {4'h0, pd, pde, da, dae});
    repeat (3) @(posedge mclk_i);
    uacc(ahi_pkg::UA_PINS, 0, 0);
    chk("pin inputs", {4'h0, pins[0], pins[1], 2'b00}, q & 8'h0c);
    uacc(ahi_pkg::UA_FLOW, 1, 8'h0d);
    for (int i = 0; i < 13; i++) begin
      fb[i] = $urandom;
      uacc(ahi_pkg::UA_FIFO, 1, fb[i]);
    end
    for (int i = 0; i < 12; i++) begin
      host.acc(ahi_pkg::HC_DATA, 0, 0, q);
      chk("fifo data", fb[i], q);
    end
    end_of_test();
  end
endmodule
